/* design/rx_fifo_flow_control_trigger.sv */
`timescale 1ns/1ps

// Summary of operation
// - With any-frame set, react at trigger level: jam in half, pause in full.
// - Full-duplex pause logic runs only with any-frame set and full duplex.
// - Half duplex any-frame: skip address decode, jam on valid preamble.
// - Full duplex any-frame: request pause at once when level is reached.
// - Pause request is held until the MAC takes it; nothing is aborted.
// - Any-frame set overrides multicast, broadcast and address-match flags.
// - Four-bit code picks 5 to 600 us jam; 10 Mb/s adds 2.2 us.
// - High threshold counts 64-byte units; reaching it starts pause or jam.
// - Zero-time pause once fill drops below low threshold after a pause.
// - Jam duration code only matters in half duplex.
// - Half duplex flags jam on multicast, broadcast or own-address frames.
module rx_fifo_flow_control_trigger
	import flow_trigger_pkg::*;
	#(
	parameter int LEVEL_W           = 14,
	parameter int CNT_W             = 18,
	parameter int JAM_UNIT_NS       = JAM_UNIT_US * 1000,
	parameter int JAM_SLOW_EXTRA    = JAM_SLOW_EXTRA_NS
	)
	(
	// Clock and reset.
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Link state and receive path.
	input  wire logic [LEVEL_W-1:0] rx_fifo_level,
	input  wire logic               full_duplex,
	input  wire logic               speed_100,
	input  wire logic               rx_preamble,
	input  wire logic               rx_addr_valid,
	input  wire logic               rx_is_multicast,
	input  wire logic               rx_is_broadcast,
	input  wire logic               rx_is_addr_match,
	// MAC transmitter.
	output logic                    jam,
	output logic                    pause_req,
	output logic [PTIME_W-1:0]      pause_time,
	input  wire logic               pause_ack
	);

	logic [31:0]        ctrl;
	logic [31:0]        pause_cfg;
	logic               aw_held;
	logic               w_held;
	logic [7:0]         aw_addr;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               paused;
	logic [CNT_W-1:0]   jam_load;
	logic [CNT_W-1:0]   jam_count;
	logic [THR_W-1:0]   fill_units;
	logic               high_reached;
	logic               below_low;
	logic               fd_any;
	logic               hd_match;
	logic               hd_trigger;
	logic               fire_high;
	logic               fire_low;
	logic [31:0]        status;
	logic               any_flag;

	// Field views of the control register.
	assign any_flag   = ctrl[ANY_BIT];
	assign fill_units = THR_W'(rx_fifo_level >> FILL_UNIT_SHIFT);
	assign high_reached = fill_units >= ctrl[HI_LSB +: THR_W];
	assign below_low    = fill_units < ctrl[LO_LSB +: THR_W];

	// Trigger decisions. Any-frame masks the per-type flags entirely.
	assign fd_any   = full_duplex && any_flag;
	assign hd_match = any_flag ? rx_preamble
		: rx_addr_valid && ((ctrl[MULT_BIT] && rx_is_multicast)
		|| (ctrl[BRD_BIT] && rx_is_broadcast)
		|| (ctrl[ADDR_BIT] && rx_is_addr_match));
	assign hd_trigger = !full_duplex && high_reached && hd_match;
	assign fire_high  = fd_any && high_reached && !paused;
	assign fire_low   = fd_any && paused && below_low;

	// Jam length: table units times the unit time, plus the slow-link extra.
	always_comb
	begin
		jam_load = CNT_W'((jam_units(ctrl[DUR_LSB +: DUR_W]) * JAM_UNIT_NS
			+ (speed_100 ? 0 : JAM_SLOW_EXTRA)) / CLK_PERIOD_NS);
	end

	// Full duplex clears the timer so the code has no effect there.
	jam_timer #(.CNT_W(CNT_W)) u_jam_timer
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (hd_trigger),
		.clear   (full_duplex),
		.load    (jam_load),
		.active  (jam),
		.count   (jam_count)
	);

	// Only one pause per high crossing; the low crossing re-arms it.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			paused <= 1'b0;
		else if (fire_high)
			paused <= 1'b1;
		else if (fire_low || !fd_any)
			paused <= 1'b0;
	end

	// Request stays up until the MAC takes it; a new event wins over ack.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pause_req  <= 1'b0;
			pause_time <= '0;
		end
		else if (fire_high)
		begin
			pause_req  <= 1'b1;
			pause_time <= pause_cfg[PTIME_W-1:0];
		end
		else if (fire_low)
		begin
			pause_req  <= 1'b1;
			pause_time <= '0;
		end
		else if (pause_ack)
			pause_req  <= 1'b0;
	end

	// Write channel handshakes; address and data are taken in either order.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Latch address and data until both have arrived.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end
		else if (aw_held && w_held)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Register update with byte enables, then the write response.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl         <= CTRL_RST;
			pause_cfg    <= PAUSE_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (aw_held && w_held)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (w_strb[b] && aw_addr == CTRL_OFS)
					ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
				if (w_strb[b] && aw_addr == PAUSE_OFS)
					pause_cfg[b*8 +: 8] <= w_data[b*8 +: 8];
			end
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == CTRL_OFS || aw_addr == PAUSE_OFS)
				? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Live state for software.
	always_comb
	begin
		status            = '0;
		status[ST_JAM]    = jam;
		status[ST_REQ]    = pause_req;
		status[ST_PAUSED] = paused;
		status[ST_FDX]    = full_duplex;
		status[ST_SPEED]  = speed_100;
		status[ST_HIGH]   = high_reached;
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (s_axi_araddr)
				CTRL_OFS:   s_axi_rdata <= ctrl;
				PAUSE_OFS:  s_axi_rdata <= 32'(pause_cfg[PTIME_W-1:0]);
				STATUS_OFS: s_axi_rdata <= status;
				default:
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	a_jam_fd_off: assert property (@(posedge aclk)
		disable iff (!aresetn) $past(full_duplex) |-> !jam)
		else $error("Jam seen in full duplex.");

	a_jam_on_trigger: assert property (@(posedge aclk)
		disable iff (!aresetn) hd_trigger && jam_load != '0 |=> jam)
		else $error("Half duplex trigger did not jam.");

	a_jam_preamble: assert property (@(posedge aclk)
		disable iff (!aresetn) !full_duplex && any_flag && high_reached
		&& rx_preamble && jam_load != '0
		|=> jam && jam_count == $past(jam_load))
		else $error("Preamble did not start a jam.");

	a_filter_ovr: assert property (@(posedge aclk)
		disable iff (!aresetn) any_flag && !rx_preamble && rx_addr_valid
		&& !jam |=> !jam)
		else $error("Type flags acted while any-frame set.");

	a_bcast_jam: assert property (@(posedge aclk)
		disable iff (!aresetn) !full_duplex && !any_flag && ctrl[BRD_BIT]
		&& rx_is_broadcast && rx_addr_valid && high_reached
		&& jam_load != '0 |=> jam)
		else $error("Broadcast frame did not jam.");

	a_pause_high: assert property (@(posedge aclk)
		disable iff (!aresetn) fd_any && high_reached && !paused |=> paused
		&& pause_req && pause_time == $past(pause_cfg[PTIME_W-1:0]))
		else $error("No pause request at high level.");

	a_pause_zero: assert property (@(posedge aclk)
		disable iff (!aresetn) fd_any && paused && below_low
		|=> pause_req && pause_time == '0 && !paused)
		else $error("No zero-time pause at low level.");

	a_req_hold: assert property (@(posedge aclk)
		disable iff (!aresetn) pause_req && !pause_ack |=> pause_req)
		else $error("Pause request dropped before ack.");

	a_fd_gate: assert property (@(posedge aclk)
		disable iff (!aresetn) !fd_any |=> !paused)
		else $error("Pause armed without full duplex any-frame.");

endmodule

/* design/flow_trigger_pkg.sv */
package flow_trigger_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] PAUSE_OFS  = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	// Control register field positions.
	localparam int HI_LSB   = 16;
	localparam int LO_LSB   = 8;
	localparam int DUR_LSB  = 4;
	localparam int MULT_BIT = 3;
	localparam int BRD_BIT  = 2;
	localparam int ADDR_BIT = 1;
	localparam int ANY_BIT  = 0;
	localparam int THR_W    = 8;
	localparam int DUR_W    = 4;
	localparam int PTIME_W  = 16;

	// Status register bit positions.
	localparam int ST_JAM    = 0;
	localparam int ST_REQ    = 1;
	localparam int ST_PAUSED = 2;
	localparam int ST_FDX    = 3;
	localparam int ST_SPEED  = 4;
	localparam int ST_HIGH   = 5;

	// Reset values of the writable registers.
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] PAUSE_RST = 32'h0000_0000;

	// Fill level is compared in units of 64 bytes.
	localparam int FILL_UNIT_SHIFT = 6;

	// Timing: system clock period and jam duration building blocks.
	localparam int CLK_PERIOD_NS     = 5;
	localparam int JAM_UNIT_US       = 5;
	localparam int JAM_SLOW_EXTRA_NS = 2200;
	localparam int JAM_STEP_UNITS    = 10;
	localparam int JAM_LONG_BASE     = 3;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Duration code to a count of 5 us units: 1,2,3,5, then steps of 50 us.
	function automatic int jam_units(input logic [DUR_W-1:0] code);
		int units;
		units = 0;
		case (code)
			4'h0: units = 1;
			4'h1: units = 2;
			4'h2: units = 3;
			4'h3: units = 5;
			default: units = (int'(code) - JAM_LONG_BASE) * JAM_STEP_UNITS;
		endcase
		return units;
	endfunction

endpackage

/* design/jam_timer.sv */
`timescale 1ns/1ps

module jam_timer
	#(
	parameter int CNT_W = 18
	)
	(
	// Clock and reset.
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Control.
	input  wire logic             start,
	input  wire logic             clear,
	input  wire logic [CNT_W-1:0] load,
	// State.
	output logic                  active,
	output logic [CNT_W-1:0]      count
	);

	// A new start reloads the counter, so a fresh frame extends the jam.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count  <= '0;
			active <= 1'b0;
		end
		else if (clear)
		begin
			count  <= '0;
			active <= 1'b0;
		end
		else if (start)
		begin
			count  <= load;
			active <= (load != '0);
		end
		else if (count != '0)
		begin
			count  <= count - 1'b1;
			active <= (count != CNT_W'(1));
		end
	end

	a_timer_load: assert property (@(posedge aclk)
		disable iff (!aresetn) start && !clear |=> count == $past(load))
		else $error("Jam timer did not load its count.");

endmodule

/* testbench/mac_tx_model.sv */
`timescale 1ns/1ps

// Transmitter stand-in. It sends a pause frame only when no frame is on
// the wire, so a request made in mid-frame waits instead of cutting in.
module mac_tx_model
	(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Request from the trigger.
	input  wire logic        pause_req,
	input  wire logic [15:0] pause_time,
	input  wire logic        slow,
	output logic             pause_ack,
	// Record of frames sent.
	output logic [7:0]       n_sent,
	output logic [15:0]      last_time
	);
	logic [7:0] busy;

	// A slow link keeps each frame on the wire longer before the next one.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pause_ack <= 1'b0;
			busy      <= 8'h00;
			n_sent    <= 8'h00;
			last_time <= 16'h0000;
		end
		else if (busy != 8'h00)
		begin
			pause_ack <= 1'b0;
			busy      <= busy - 8'h01;
		end
		else if (pause_req)
		begin
			pause_ack <= 1'b1;
			n_sent    <= n_sent + 8'h01;
			last_time <= pause_time;
			busy      <= slow ? 8'h14 : 8'h02;
		end
		else
			pause_ack <= 1'b0;
	end
endmodule

/* testbench/test_rx_fifo_flow_control_trigger.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
 $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module test_rx_fifo_flow_control_trigger;
	import flow_trigger_pkg::*;
	localparam int UNIT  = 10;
	localparam int EXTRA = 5;
	logic        aclk = 0, aresetn = 0, slow = 0;
	logic [7:0]  awaddr = 0, araddr = 0, n_sent;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, q;
	logic        awready, wready, bvalid, arready, rvalid, jam, preq, pack;
	logic [1:0]  bresp, rresp, r;
	logic [13:0] level = 0;
	logic        fdx = 0, spd = 1, pre = 0, aok = 0;
	logic [2:0]  v = 0;
	logic [15:0] ptime, last_time, pv;
	int          n_fail = 0, cmp_count = 0, cyc = 0, n, k;

	// Clock and the design with shortened jam units.
	always #2.5 aclk = ~aclk;
	rx_fifo_flow_control_trigger #(.JAM_UNIT_NS(UNIT),
		.JAM_SLOW_EXTRA(EXTRA)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_fifo_level(level), .full_duplex(fdx), .speed_100(spd),
		.rx_preamble(pre), .rx_addr_valid(aok), .rx_is_multicast(v[2]),
		.rx_is_broadcast(v[1]), .rx_is_addr_match(v[0]), .jam(jam),
		.pause_req(preq), .pause_time(ptime), .pause_ack(pack));
	mac_tx_model mac (.aclk(aclk), .aresetn(aresetn), .pause_req(preq),
		.pause_time(ptime), .slow(slow), .pause_ack(pack),
		.n_sent(n_sent), .last_time(last_time));

	// Cycle count of a jam for a duration code and link speed.
	function automatic int exp_len(input logic [3:0] c, input logic s);
		int u;
		u = (c < 4) ? ((c == 3) ? 5 : int'(c) + 1) : (int'(c) - 3) * 10;
		return (u * UNIT + (s ? 0 : EXTRA)) / 5;
	endfunction

	// Bus tasks read handshakes just after an edge, before that edge's
	// updates land, so each one sees what the design showed at the edge.
	// They wait as long as needed; only the run's own timeout ends a wait.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1;
		wvalid  <= 1;
		bready  <= 1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1;
		rready  <= 1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end
		while (rvalid !== 1'b1);
		q = rdata;
		r = rresp;
		rready <= 0;
	endtask

	// One frame start (preamble or decoded address); n gets the jam length.
	task automatic frame(input bit p);
		@(posedge aclk);
		pre <= p;
		aok <= !p;
		@(posedge aclk);
		pre <= 0;
		aok <= 0;
		n = 0;
		@(posedge aclk);
		while (jam === 1'b1 && n < 3000)
		begin
			n++;
			@(posedge aclk);
		end
	endtask

	task automatic wait_sent(input logic [7:0] t);
		int i;
		for (i = 0; i < 100 && n_sent !== t; i++) @(posedge aclk);
		`CHK("frames sent", t, n_sent)
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A hang is cut short well beyond the expected run length.
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial
	begin
		n = $urandom(32'hc2233e8d);
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		// Control register reset value and refused accesses.
		rd(CTRL_OFS);
		`CHK("ctrl reset", CTRL_RST, q)
		rd(8'h0c);
		`CHK("unmapped read resp", RESP_SLVERR, r)
		wr(STATUS_OFS, 32'h0000_003f);
		`CHK("status write resp", RESP_SLVERR, r)
		pv = 16'($urandom);
		wr(PAUSE_OFS, {16'h0000, pv});
		`CHK("pause write resp", RESP_OKAY, r)
		rd(PAUSE_OFS);
		`CHK("pause readback", {16'h0000, pv}, q)
		`CHK("pause read resp", RESP_OKAY, r)
		// Below the trigger level no frame is jammed.
		level <= 14'd127;
		wr(CTRL_OFS, 32'h0002_0001);
		frame(1);
		`CHK("jam below level", 0, n)
		// Every duration code at a random speed, any-frame on preamble.
		for (k = 0; k < 16; k++)
		begin
			spd   <= 1'($urandom);
			level <= 14'(128 + $urandom % 8000);
			wr(CTRL_OFS, 32'h0002_0001 | (k << DUR_LSB));
			frame(1);
			`CHK("jam cycles", exp_len(4'(k), spd), n)
		end
		// Address decode skipped with any-frame set, type flags ignored.
		v <= 3'h7;
		wr(CTRL_OFS, 32'h0002_000f);
		frame(0);
		`CHK("jam on address", 0, n)
		// Type flags one at a time: every type, all but the selected one,
		// then random frame types.
		for (k = 0; k < 8; k++)
		begin
			v <= (k < 3) ? 3'h7 : (k < 6) ? ~(3'h1 << (k % 3)) : 3'($urandom);
			wr(CTRL_OFS, 32'h0002_0000 | (2 << (k % 3)));
			frame(0);
			`CHK("jam by type", v[k % 3] ? exp_len(0, spd) : 0, n)
		end
		// Full duplex: no jam, one pause at the high level, zero on resume.
		fdx   <= 1;
		slow  <= 1'($urandom);
		level <= 0;
		wr(CTRL_OFS, 32'h0004_02f1);
		frame(1);
		`CHK("jam in full duplex", 0, n)
		level <= 14'(4 * 64 + $urandom % 64);
		wait_sent(8'h01);
		`CHK("pause time", pv, last_time)
		// Pause acknowledged: level high, paused, request already dropped.
		rd(STATUS_OFS);
		k = (1 << ST_HIGH) | (1 << ST_FDX) | (1 << ST_PAUSED);
		k = k | (int'(spd) << ST_SPEED);
		`CHK("status", k, q)
		level <= 14'(2 * 64 + $urandom % 64);
		repeat (40) @(posedge aclk);
		`CHK("single pause", 8'h01, n_sent)
		level <= 14'($urandom % 128);
		wait_sent(8'h02);
		`CHK("zero pause time", 16'h0000, last_time)
		// Without any-frame the full-duplex pause stays off.
		wr(CTRL_OFS, 32'h0004_020e);
		level <= 14'(6 * 64);
		repeat (40) @(posedge aclk);
		`CHK("pause without any", 8'h02, n_sent)
		tally_and_finish();
	end
endmodule
